// ===== core/dmacc_pkg.sv
// Purpose: constants for the dma channel control block
// Assumes: axi4-lite register access, 32-bit data words
// Notes:   printed offsets are not all multiples of four, so each is kept as an index
package dmacc_pkg;
  localparam logic [31:0] DMACC_IDX_COUNT  = 32'h5000360A;
  localparam logic [31:0] DMACC_IDX_CTRL   = 32'h5000360C;
  localparam logic [31:0] DMACC_IDX_SRCL   = 32'h50003600;
  localparam logic [31:0] DMACC_IDX_SRCH   = 32'h50003602;
  localparam logic [31:0] DMACC_IDX_DSTL   = 32'h50003604;
  localparam logic [31:0] DMACC_IDX_DSTH   = 32'h50003606;
  localparam logic [31:0] DMACC_IDX_THRESH = 32'h50003608;
  localparam logic [31:0] DMACC_IDX_INDEX  = 32'h5000360E;
  localparam logic [31:0] DMACC_IDX_STATUS = 32'h50003610;
  localparam int          DMACC_ADDR_W     = 12;
  localparam int          DMACC_RUN        = 0;
  localparam int          DMACC_WID_LO     = 1;
  localparam int          DMACC_IRQ_EN     = 3;
  localparam int          DMACC_TRIG       = 4;
  localparam int          DMACC_DST_STEP   = 5;
  localparam int          DMACC_SRC_STEP   = 6;
  localparam int          DMACC_CIRC       = 7;
  localparam int          DMACC_PRIO_LO    = 8;
  localparam int          DMACC_YIELD      = 11;
  localparam int          DMACC_FILL       = 12;
  localparam int          DMACC_EDGE       = 13;
  localparam logic [15:0] DMACC_CTRL_MASK  = 16'h3FFF;
  localparam logic [15:0] DMACC_RST16      = 16'h0000;
  localparam logic [1:0]  DMACC_W_BYTE     = 2'h0;
  localparam logic [1:0]  DMACC_W_HALF     = 2'h1;
  localparam logic [1:0]  DMACC_W_WORD     = 2'h2;
  localparam logic [1:0]  DMACC_RESP_OK    = 2'h0;
  localparam logic [1:0]  DMACC_RESP_ERR   = 2'h2;
  typedef enum logic [2:0] {
    DMACC_IDLE, DMACC_ARB, DMACC_RD, DMACC_WR, DMACC_GAP
  } dmacc_state_t;
  function automatic logic [DMACC_ADDR_W-1:0] dmacc_byte(input logic [31:0] idx);
    return {idx[DMACC_ADDR_W-3:0], 2'b00};
  endfunction
endpackage

// ===== core/dmacc_top.sv
// Purpose: control, length and bus sequencing of one dma channel
// Assumes: single clock, synchronous active-high reset, request is synchronous
// Notes:   this channel arbitrates against other channels via arb_* ports
// Notes on behaviour
// (RL1) moves transfer count plus one items; count zero moves one item
// (RL2) control bit 13 picks level or rising-edge peripheral request sensing
// (RL3) fill mode reads source once and writes it to every destination
// (RL4) software must enable destination stepping in fill mode; source step ignored
// (RL5) fill transfer runs to the end without yielding to other channels
// (RL6) software should not mix fill mode with peripheral triggering
// (RL7) blocking mode copies back to back, holding the bus from lower masters
// (RL8) yield mode idles one cycle after each store; ignored when peripheral-triggered
// (RL9) 3-bit priority in bits 10:8, larger value wins arbitration
// (RL10) equal priority goes to the lowest-numbered channel
// (RL11) normal mode stops at the end and clears the run bit
// (RL12) circular peripheral mode zeroes index, restarts, keeps run bit
// (RL13) bit 6 steps the source address by the width after each item
// (RL14) bit 5 steps the destination address by the width after each item
// (RL15) step is 1, 2 or 4 for width codes 00, 01, 10
// (RL16) bit 4 clear starts at once, set waits for peripheral request
// (RL17) bit 3 gates the channel interrupt output
// (RL18) width field bits 2:1 selects byte, half or word; 11 reserved
// (RL19) run bit clear keeps channel idle; setting it enables the channel
// (RL20) interrupt when threshold equals index after an item, before index steps
// (RL21) read-only index counts items and returns to zero on completion
// (RL22) source and destination start addresses written as two 16-bit halves
// (RL23) bus address is start plus index times step, or start alone
// (RL24) control bits 15:14 read zero and ignore writes
`timescale 1ns/100ps
`default_nettype none
module dmacc_top
  import dmacc_pkg::*;
#(
  parameter logic [2:0] CHAN_NUM = 3'h0
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [DMACC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [DMACC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    periph_req,
  output logic                         arb_req,
  output logic [2:0]                   arb_prio,
  output logic                         arb_lock,
  input  wire logic                    arb_grant,
  output logic                         mem_valid,
  output logic                         mem_write,
  output logic [31:0]                  mem_addr,
  output logic [1:0]                   mem_size,
  output logic [31:0]                  mem_wdata,
  input  wire logic                    mem_ready,
  input  wire logic [31:0]             mem_rdata,
  output logic                         bus_hold,
  output logic                         irq
);

  typedef struct packed {
    logic         awready;
    logic         wready;
    logic         aw_got;
    logic         w_got;
    logic [DMACC_ADDR_W-1:0] aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [15:0]  count;
    logic [15:0]  ctrl;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [15:0]  thresh;
    logic [15:0]  index;
    logic         req_prev;
    logic         req_seen;
    logic         done_flag;
    dmacc_state_t st;
    logic         fill_loaded;
    logic [31:0]  data;
    logic         mvalid;
    logic         mwrite;
    logic [31:0]  maddr;
    logic [31:0]  mwdata;
    logic         areq;
    logic         alock;
    logic         hold;
    logic         irq;
  } dmacc_regs_t;

  dmacc_regs_t q, d;

  logic [31:0] step;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic        last_item;
  logic        trig_mode;
  logic        req_ok;
  logic [15:0] wmask;
  logic [31:0] widx;
  logic [31:0] ridx;
  logic        wr_fire;

  always_comb begin
    // see (RL15) (RL18)
    unique case (q.ctrl[DMACC_WID_LO +: 2])
      DMACC_W_HALF: step = 32'h00000002;
      DMACC_W_WORD: step = 32'h00000004;
      default:      step = 32'h00000001;
    endcase
    // see (RL13) (RL14) (RL23)
    src_addr  = q.ctrl[DMACC_SRC_STEP] ? q.src + step * {16'h0000, q.index} : q.src;
    dst_addr  = q.ctrl[DMACC_DST_STEP] ? q.dst + step * {16'h0000, q.index} : q.dst;
    last_item = (q.index == q.count);                       // see (RL1)
    trig_mode = q.ctrl[DMACC_TRIG];
    // see (RL2) (RL16)
    req_ok    = !trig_mode || (q.ctrl[DMACC_EDGE] ? q.req_seen : periph_req);
    wmask     = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
    // word index mapped back onto the register offsets; top two address bits must be zero
    widx      = (q.aw_addr[DMACC_ADDR_W-1 -: 2] == 2'h0) ?
                {DMACC_IDX_SRCL[31:8], q.aw_addr[DMACC_ADDR_W-3:2]} : 32'hFFFFFFFF;
    ridx      = (s_axi_araddr[DMACC_ADDR_W-1 -: 2] == 2'h0) ?
                {DMACC_IDX_SRCL[31:8], s_axi_araddr[DMACC_ADDR_W-3:2]} : 32'hFFFFFFFF;
    wr_fire   = q.aw_got && q.w_got && !q.bvalid;
  end

  always_comb begin
    d = q;
    d.req_prev = periph_req;
    if (periph_req && !q.req_prev) begin
      d.req_seen = 1'b1;
    end
    // write channel: address and data accepted in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
      d.wready = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = DMACC_RESP_OK;
      if (widx == DMACC_IDX_COUNT) begin
        d.count = (q.count & ~wmask) | (q.w_data[15:0] & wmask);
      end else if (widx == DMACC_IDX_CTRL) begin
        // see (RL24)
        d.ctrl = ((q.ctrl & ~wmask) | (q.w_data[15:0] & wmask)) & DMACC_CTRL_MASK;
      end else if (widx == DMACC_IDX_SRCL) begin
        d.src[15:0] = (q.src[15:0] & ~wmask) | (q.w_data[15:0] & wmask);  // see (RL22)
      end else if (widx == DMACC_IDX_SRCH) begin
        d.src[31:16] = (q.src[31:16] & ~wmask) | (q.w_data[15:0] & wmask);
      end else if (widx == DMACC_IDX_DSTL) begin
        d.dst[15:0] = (q.dst[15:0] & ~wmask) | (q.w_data[15:0] & wmask);
      end else if (widx == DMACC_IDX_DSTH) begin
        d.dst[31:16] = (q.dst[31:16] & ~wmask) | (q.w_data[15:0] & wmask);
      end else if (widx == DMACC_IDX_THRESH) begin
        d.thresh = (q.thresh & ~wmask) | (q.w_data[15:0] & wmask);
      end else if (widx == DMACC_IDX_STATUS) begin
        if (q.w_data[0] && q.w_strb[0]) begin
          d.done_flag = 1'b0;
        end
      end else if (widx != DMACC_IDX_INDEX) begin
        d.bresp = DMACC_RESP_ERR;
      end
    end
    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = DMACC_RESP_OK;
      d.rdata   = 32'h00000000;
      if (ridx == DMACC_IDX_COUNT) begin
        d.rdata[15:0] = q.count;
      end else if (ridx == DMACC_IDX_CTRL) begin
        d.rdata[15:0] = q.ctrl;
      end else if (ridx == DMACC_IDX_SRCL) begin
        d.rdata[15:0] = q.src[15:0];
      end else if (ridx == DMACC_IDX_SRCH) begin
        d.rdata[15:0] = q.src[31:16];
      end else if (ridx == DMACC_IDX_DSTL) begin
        d.rdata[15:0] = q.dst[15:0];
      end else if (ridx == DMACC_IDX_DSTH) begin
        d.rdata[15:0] = q.dst[31:16];
      end else if (ridx == DMACC_IDX_THRESH) begin
        d.rdata[15:0] = q.thresh;
      end else if (ridx == DMACC_IDX_INDEX) begin
        d.rdata[15:0] = q.index;                            // see (RL21)
      end else if (ridx == DMACC_IDX_STATUS) begin
        d.rdata[2:0] = {q.irq, q.st != DMACC_IDLE, q.done_flag};
      end else begin
        d.rresp = DMACC_RESP_ERR;
      end
    end
    d.irq = 1'b0;
    // channel sequencer
    unique case (q.st)
      DMACC_IDLE: begin
        d.index       = 16'h0000;
        d.fill_loaded = 1'b0;
        d.hold        = 1'b0;
        if (q.ctrl[DMACC_RUN]) begin                        // see (RL19)
          d.st = DMACC_ARB;
        end
      end
      DMACC_ARB: begin
        d.areq = req_ok;
        if (!q.ctrl[DMACC_RUN]) begin
          d.areq = 1'b0;
          d.st   = DMACC_IDLE;
        end else if (q.areq && arb_grant && req_ok) begin  // see (RL9) (RL10)
          d.req_seen = periph_req && !q.req_prev;           // a new edge now is kept
          d.hold     = 1'b1;
          // see (RL5)
          d.alock = q.ctrl[DMACC_FILL] || !q.ctrl[DMACC_YIELD] || trig_mode;
          if (q.ctrl[DMACC_FILL] && q.fill_loaded) begin
            d.st     = DMACC_WR;                            // see (RL3)
            d.mvalid = 1'b1;
            d.mwrite = 1'b1;
            d.maddr  = dst_addr;
            d.mwdata = q.data;
          end else begin
            d.st     = DMACC_RD;
            d.mvalid = 1'b1;
            d.mwrite = 1'b0;
            d.maddr  = src_addr;
          end
        end
      end
      DMACC_RD: begin
        if (mem_ready) begin
          d.data        = mem_rdata;
          d.fill_loaded = 1'b1;
          d.st          = DMACC_WR;
          d.mwrite      = 1'b1;
          d.maddr       = dst_addr;
          d.mwdata      = mem_rdata;
        end
      end
      DMACC_WR: begin
        if (mem_ready) begin
          d.mvalid = 1'b0;
          d.mwrite = 1'b0;
          // see (RL17) (RL20)
          d.irq = q.ctrl[DMACC_IRQ_EN] && (q.thresh == q.index);
          if (last_item) begin
            d.index       = 16'h0000;                       // see (RL21)
            d.fill_loaded = 1'b0;
            d.done_flag   = 1'b1;
            d.areq        = 1'b0;
            d.alock       = 1'b0;
            d.hold        = 1'b0;
            if (q.ctrl[DMACC_CIRC] && trig_mode) begin
              d.st = DMACC_ARB;                             // see (RL12)
            end else begin
              d.ctrl[DMACC_RUN] = 1'b0;                     // see (RL11)
              d.st              = DMACC_IDLE;
            end
          end else begin
            d.index = q.index + 16'h0001;
            if (trig_mode) begin
              d.areq  = 1'b0;
              d.alock = 1'b0;
              d.hold  = 1'b0;
              d.st    = DMACC_ARB;
            end else if (q.ctrl[DMACC_YIELD] && !q.ctrl[DMACC_FILL]) begin
              d.hold = 1'b0;                                // see (RL8)
              d.st   = DMACC_GAP;
            end else begin
              d.st = DMACC_ARB;                             // see (RL7)
            end
          end
        end
      end
      DMACC_GAP: begin
        d.st = DMACC_ARB;
      end
      default: begin
        d.st = DMACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.st      <= DMACC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign arb_req       = q.areq;
  assign arb_prio      = q.ctrl[DMACC_PRIO_LO +: 3];
  assign arb_lock      = q.alock;
  assign mem_valid     = q.mvalid;
  assign mem_write     = q.mwrite;
  assign mem_addr      = q.maddr;
  assign mem_size      = q.ctrl[DMACC_WID_LO +: 2];
  assign mem_wdata     = q.mwdata;
  assign bus_hold      = q.hold;
  assign irq           = q.irq;

endmodule
`default_nettype wire

// ===== dv/dmacc_mem_model.sv
// Purpose: system bus and arbiter stand-in for one dma channel
// Assumes: grant is a level that follows the request
// Notes:   slow adds three wait cycles to every bus access
`timescale 1ns/100ps
`default_nettype none
module dmacc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        arb_req,
  output logic             arb_grant,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata,
  output logic [31:0]      rd_n,
  output logic [31:0]      wr_n,
  output logic [31:0]      lst_a,
  output logic [31:0]      lst_d
);
  logic [1:0] wait_q;
  always_ff @(posedge core_clk) begin
    mem_ready <= 1'b0;
    // read data is only valid with ready, garbage otherwise
    mem_rdata <= ~mem_rdata;
    arb_grant <= arb_req && !rst;
    if (rst) begin
      wait_q <= 2'h0;
      rd_n <= 32'h0;
      wr_n <= 32'h0;
      mem_rdata <= 32'h0F0F0F0F;
    end else if (mem_valid && !mem_ready) begin
      if (wait_q == (slow ? 2'h3 : 2'h0)) begin
        mem_ready <= 1'b1;
        wait_q <= 2'h0;
        if (mem_write) begin
          wr_n <= wr_n + 32'h1;
          lst_a <= mem_addr;
          lst_d <= mem_wdata;
        end else begin
          rd_n <= rd_n + 32'h1;
          mem_rdata <= {mem_addr[15:0] ^ 16'h5A5A, mem_addr[15:0]};
        end
      end else wait_q <= wait_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/dmacc_properties.sv
// Purpose: concurrent checks on the dma channel ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every dmacc_top instance
`timescale 1ns/100ps
`default_nettype none
module dmacc_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        arb_req,
  input wire logic        mem_valid,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0]  mem_size,
  input wire logic        mem_ready,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_req_steady: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable({mem_write, mem_addr, mem_size}))
    else $error("bus request changed before ready");
  chk_write_follows: assert property (
    mem_valid && !mem_write && mem_ready |=> mem_valid && mem_write)
    else $error("no store right after the load");
  chk_arb_first: assert property (
    $rose(mem_valid) |-> $past(arb_req))
    else $error("bus access without arbitration");
  chk_width_legal: assert property (
    mem_valid |-> mem_size != 2'h3)
    else $error("reserved item width on the bus");
  chk_irq_pulse: assert property (
    irq |=> !irq)
    else $error("interrupt longer than one cycle");
  chk_irq_cause: assert property (
    irq |-> $past(mem_write && mem_ready) || $past(mem_write && mem_ready, 2))
    else $error("interrupt without a finished store");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind dmacc_top dmacc_properties u_dmacc_properties (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .arb_req(arb_req), .mem_valid(mem_valid),
  .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
  .mem_ready(mem_ready), .irq(irq)
);
`default_nettype wire

// ===== dv/dmacc_top_test.sv
// Purpose: register-level tests of one dma channel
// Assumes: bus stand-in answers every access
// Notes:   expected data follows the stand-in's address pattern
`timescale 1ns/100ps
`default_nettype none
module dmacc_top_test
  import dmacc_pkg::*;
;
  localparam logic [11:0] A_SL = 12'h000, A_SH = 12'h008, A_DL = 12'h010, A_DH = 12'h018;
  localparam logic [11:0] A_TH = 12'h020, A_CNT = 12'h028, A_CTL = 12'h030, A_IDX = 12'h038;
  localparam logic [11:0] A_ST = 12'h040;
  logic        core_clk = 1'b0, rst = 1'b1, slow = 1'b0, preq = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, mrdata, maddr, mwdata, got, rd_n, wr_n, lst_a, lst_d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, areq, alock, agrant;
  logic        mvalid, mwrite, mready, hold, irq;
  logic [1:0]  bresp, rresp, gresp, wresp, msize;
  logic [2:0]  aprio, last_prio;
  logic [31:0] b_rd, b_wr, b_irq, b_gap, b_lock;
  int          fail_count = 0, compares = 0, cyc = 0, irqs = 0, holds = 0, gaps = 0, locks = 0;
  dmacc_top u_dmacc_top (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_req(preq), .arb_req(areq), .arb_prio(aprio), .arb_lock(alock),
    .arb_grant(agrant), .mem_valid(mvalid), .mem_write(mwrite), .mem_addr(maddr),
    .mem_size(msize), .mem_wdata(mwdata), .mem_ready(mready), .mem_rdata(mrdata),
    .bus_hold(hold), .irq(irq));
  dmacc_mem_model u_dmacc_mem_model (
    .core_clk(core_clk), .rst(rst), .slow(slow), .arb_req(areq), .arb_grant(agrant),
    .mem_valid(mvalid), .mem_write(mwrite), .mem_addr(maddr), .mem_wdata(mwdata),
    .mem_ready(mready), .mem_rdata(mrdata), .rd_n(rd_n), .wr_n(wr_n), .lst_a(lst_a),
    .lst_d(lst_d));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (hold === 1'b1) holds++;
    if (areq === 1'b1 && hold === 1'b0) gaps++;
    if (mvalid === 1'b1 && alock === 1'b1) locks++;
    if (areq === 1'b1) last_prio = aprio;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge core_clk);
    while (awvalid || wvalid || bready) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        wresp = bresp;
      end
      @(posedge core_clk);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge core_clk);
    while (rready) begin
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = rdata;
        gresp = rresp;
        rready <= 1'b0;
      end
      @(posedge core_clk);
    end
  endtask
  task automatic rck(input logic [11:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, got);
  endtask
  task automatic mark;
    b_rd = rd_n;
    b_wr = wr_n;
    b_irq = irqs;
    b_gap = gaps;
    b_lock = locks;
  endtask
  task automatic wait_off;
    got = 32'h1;
    while (got[0] === 1'b1) rd(A_CTL);
  endtask
  task automatic res(input logic [31:0] er, ew, ea, ed, em);
    chk("reads", b_rd + er, rd_n);
    chk("writes", b_wr + ew, wr_n);
    chk("last dst", ea, lst_a);
    chk("last data", ed & em, lst_d & em);
  endtask
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, a[15:0]};
  endfunction
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rck(A_CNT, 32'h0, "count reset");
    rck(A_CTL, 32'h0, "ctrl reset");
    wr(A_CTL, 16'hC000);
    rck(A_CTL, 32'h0, "ctrl top bits");
    rd(12'h0FC);
    chk("unmapped resp", {30'h0, DMACC_RESP_ERR}, {30'h0, gresp});
    wr(A_IDX, 16'h0005);
    chk("index wr resp", {30'h0, DMACC_RESP_OK}, {30'h0, wresp});
    rck(A_IDX, 32'h0, "index read only");
    wr(12'h0FC, 16'h0000);
    chk("unmapped wr resp", {30'h0, DMACC_RESP_ERR}, {30'h0, wresp});
    $display("test registers finished");
    wr(A_SL, 16'h1230);
    wr(A_SH, 16'h0001);
    wr(A_DL, 16'h2000);
    wr(A_DH, 16'h0003);
    wr(A_TH, 16'h0001);
    wr(A_CNT, 16'h0002);
    mark();
    wr(A_CTL, 16'h006D);
    wait_off();
    res(3, 3, 32'h00032008, pat(32'h00011238), 32'hFFFFFFFF);
    chk("irqs", b_irq + 1, irqs);
    chk("hold seen", 32'h1, {31'h0, holds != 0});
    chk("block gaps", b_gap + 2, gaps);
    rck(A_IDX, 32'h0, "index");
    rck(A_CTL, 32'h006C, "run cleared");
    rck(A_ST, 32'h1, "done flag");
    wr(A_ST, 16'h0001);
    rck(A_ST, 32'h0, "done cleared");
    $display("test word copy finished");
    slow <= 1'b1;
    mark();
    wr(A_CTL, 16'h1D63);
    wait_off();
    res(1, 3, 32'h00032004, pat(32'h00011230), 32'h0000FFFF);
    chk("no irq", b_irq, irqs);
    chk("prio", 32'h5, {29'h0, last_prio});
    chk("fill lock", 32'h1, {31'h0, locks > b_lock});
    chk("item size", 32'h1, {30'h0, msize});
    slow <= 1'b0;
    $display("test fill finished");
    mark();
    wr(A_CTL, 16'h0865);
    wait_off();
    res(3, 3, 32'h00032008, pat(32'h00011238), 32'hFFFFFFFF);
    chk("yield gaps", b_gap + 6, gaps);
    chk("yield lock", b_lock, locks);
    $display("test yield finished");
    wr(A_CNT, 16'h0001);
    mark();
    wr(A_CTL, 16'h0011);
    repeat (20) @(posedge core_clk);
    chk("idle writes", b_wr, wr_n);
    preq <= 1'b1;
    wait_off();
    preq <= 1'b0;
    res(2, 2, 32'h00032000, pat(32'h00011230), 32'h000000FF);
    $display("test level trigger finished");
    wr(A_CNT, 16'h0000);
    mark();
    wr(A_CTL, 16'h2091);
    preq <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk("edge writes", b_wr + 1, wr_n);
    preq <= 1'b0;
    @(posedge core_clk);
    preq <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk("circ writes", b_wr + 2, wr_n);
    rck(A_CTL, 32'h2091, "run kept");
    preq <= 1'b0;
    wr(A_CTL, 16'h0000);
    $display("test circular finished");
    close_out();
  end
endmodule
`default_nettype wire
